// *** rtl/gpio_port_abc.sv ***
// gpio_port_abc: apb register file and three gpio ports (a, b, smaller-package c)
// assumes apb master on the same clock; pins are synchronised inside each port
//
// How it works
// - each register has clear, set and invert aliases at plus 0x4, 0x8, 0xc.
// - unimplemented bits and the upper halfword read zero and ignore writes.
// - pin-state and latch contents are not reset; undefined until written or sampled.
// - direction resets to 0xc6ff, 0xffff, 0xf000 for ports a, b, c.
// - port c implements only bits 15 to 12 in all its registers.
// - direction one makes the pin input; zero drives it from the latch, except open-drain bits whose latch is one, which are released.
// - pin-state reads sampled pins, writes go to the latch; latch reads back.
// - alias writes change only bits where the written value is one.
// - reads of alias addresses return zero, not the register.
`timescale 1ns/10ps
module gpio_port_abc (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port a pins
  input  wire logic [15:0] pins_a_in,
  output logic      [15:0] pins_a_out,
  output logic      [15:0] pins_a_oe_n,
  // port b pins
  input  wire logic [15:0] pins_b_in,
  output logic      [15:0] pins_b_out,
  output logic      [15:0] pins_b_oe_n,
  // port c pins
  input  wire logic [15:0] pins_c_in,
  output logic      [15:0] pins_c_out,
  output logic      [15:0] pins_c_oe_n
);
  // address decode
  wire        in_map    = (paddr >= gpio_pkg::map_base) && (paddr <= gpio_pkg::map_last);
  wire        aligned   = (paddr[1:0] == 2'h0);
  wire        hit       = in_map && aligned;
  wire [1:0]  port_sel  = paddr[7:6];
  wire [1:0]  kind      = paddr[5:4];
  wire [1:0]  op        = paddr[3:2];
  wire        access_wr = psel && penable && pwrite && hit;
  wire        access_rd = psel && penable && !pwrite && hit;
  // only the low halfword carries data; narrower strobes write only their lanes
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire        full_lane = (lane_mask == 16'hffff);

  // partial-lane base write merges with current contents
  logic [15:0] cur_value;
  wire  [15:0] merged   = (pwdata[15:0] & lane_mask) | (cur_value & ~lane_mask);
  wire  [15:0] wr_value = (op == gpio_pkg::alias_base) ? merged
                                                       : (pwdata[15:0] & lane_mask);
  wire         wr_dir   = access_wr && (kind == gpio_pkg::kind_direction);
  // writes to pin-state land in the latch
  wire         wr_lat   = access_wr && ((kind == gpio_pkg::kind_state) ||
                                        (kind == gpio_pkg::kind_latch));
  wire         wr_odc   = access_wr && (kind == gpio_pkg::kind_open_drain);

  logic [15:0] dir_q   [3];
  logic [15:0] lat_q   [3];
  logic [15:0] odc_q   [3];
  logic [15:0] smp_q   [3];
  logic [15:0] pin_in  [3];
  logic [15:0] pin_out [3];
  logic [15:0] pin_oen [3];

  assign pin_in[0]   = pins_a_in;
  assign pin_in[1]   = pins_b_in;
  assign pin_in[2]   = pins_c_in;
  assign pins_a_out  = pin_out[0];
  assign pins_b_out  = pin_out[1];
  assign pins_c_out  = pin_out[2];
  assign pins_a_oe_n = pin_oen[0];
  assign pins_b_oe_n = pin_oen[1];
  assign pins_c_oe_n = pin_oen[2];

  // one slice per port; port c is masked to its four pins
  gpio_port_slice #(
    .impl_mask       (gpio_pkg::mask_a),
    .direction_reset (gpio_pkg::direction_reset_a)
  ) u_port_a (
    .clock         (clock),
    .arst_n        (arst_n),
    .wr_direction  (wr_dir && port_sel == 2'h0),
    .wr_latch      (wr_lat && port_sel == 2'h0),
    .wr_open_drain (wr_odc && port_sel == 2'h0),
    .wr_op         (op),
    .wr_data       (wr_value),
    .direction     (dir_q[0]),
    .latch         (lat_q[0]),
    .open_drain    (odc_q[0]),
    .pin_sampled   (smp_q[0]),
    .pin_in        (pin_in[0]),
    .pin_out       (pin_out[0]),
    .pin_oe_n      (pin_oen[0])
  );

  gpio_port_slice #(
    .impl_mask       (gpio_pkg::mask_b),
    .direction_reset (gpio_pkg::direction_reset_b)
  ) u_port_b (
    .clock         (clock),
    .arst_n        (arst_n),
    .wr_direction  (wr_dir && port_sel == 2'h1),
    .wr_latch      (wr_lat && port_sel == 2'h1),
    .wr_open_drain (wr_odc && port_sel == 2'h1),
    .wr_op         (op),
    .wr_data       (wr_value),
    .direction     (dir_q[1]),
    .latch         (lat_q[1]),
    .open_drain    (odc_q[1]),
    .pin_sampled   (smp_q[1]),
    .pin_in        (pin_in[1]),
    .pin_out       (pin_out[1]),
    .pin_oe_n      (pin_oen[1])
  );

  gpio_port_slice #(
    .impl_mask       (gpio_pkg::mask_c),
    .direction_reset (gpio_pkg::direction_reset_c)
  ) u_port_c (
    .clock         (clock),
    .arst_n        (arst_n),
    .wr_direction  (wr_dir && port_sel == 2'h2),
    .wr_latch      (wr_lat && port_sel == 2'h2),
    .wr_open_drain (wr_odc && port_sel == 2'h2),
    .wr_op         (op),
    .wr_data       (wr_value),
    .direction     (dir_q[2]),
    .latch         (lat_q[2]),
    .open_drain    (odc_q[2]),
    .pin_sampled   (smp_q[2]),
    .pin_in        (pin_in[2]),
    .pin_out       (pin_out[2]),
    .pin_oe_n      (pin_oen[2])
  );

  // current base contents of the addressed register, used for merge and read
  always_comb begin
    cur_value = 16'h0000;
    if (port_sel != 2'h3) begin
      unique case (kind)
        gpio_pkg::kind_direction:  cur_value = dir_q[port_sel];
        gpio_pkg::kind_state:      cur_value = lat_q[port_sel];
        gpio_pkg::kind_latch:      cur_value = lat_q[port_sel];
        gpio_pkg::kind_open_drain: cur_value = odc_q[port_sel];
      endcase
    end
  end

  // pin-state reads give the sampled pins, not the latch
  wire [15:0] base_read = (kind == gpio_pkg::kind_state) ? smp_q[port_sel] : cur_value;
  // aliases return a fixed filler; upper halfword always zero
  wire [31:0] read_word = (op != gpio_pkg::alias_base) ? gpio_pkg::alias_read_value
                                                       : {16'h0000, base_read};

  // zero-wait slave; read data registered; misses and misaligned accesses get pslverr
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit ? read_word : 32'h00000000;
    end
  end

  // full_lane kept for clarity of merge path
  wire unused_ok = full_lane | access_rd;
endmodule : gpio_port_abc

// *** rtl/gpio_port_slice.sv ***
// gpio_port_slice: one 16-pin port with direction, latch, open-drain and pin sampling
// assumes write strobes and operation codes come from the apb decode on the same clock
`timescale 1ns/10ps
module gpio_port_slice #(
  parameter logic [15:0] impl_mask       = 16'hffff,
  parameter logic [15:0] direction_reset = 16'hffff
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // register write side
  input  wire logic        wr_direction,
  input  wire logic        wr_latch,
  input  wire logic        wr_open_drain,
  input  wire logic [1:0]  wr_op,
  input  wire logic [15:0] wr_data,
  // register read side
  output logic      [15:0] direction,
  output logic      [15:0] latch,
  output logic      [15:0] open_drain,
  output logic      [15:0] pin_sampled,
  // pins
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe_n
);
  logic [15:0] sync_stage;
  logic [15:0] sync_out;
  logic [15:0] next_direction;
  logic [15:0] next_latch;
  logic [15:0] next_open_drain;

  // base write replaces, aliases touch only the one bits
  function automatic logic [15:0] apply_op(input logic [15:0] cur, input logic [1:0] op,
                                           input logic [15:0] val);
    logic [15:0] res;
    res = cur;
    unique case (op)
      gpio_pkg::alias_base:       res = val;
      gpio_pkg::bit_clear_alias:  res = cur & ~val;
      gpio_pkg::bit_set_alias:    res = cur | val;
      gpio_pkg::bit_invert_alias: res = cur ^ val;
    endcase
    return res & impl_mask;
  endfunction : apply_op

  assign next_direction  = wr_direction  ? apply_op(direction, wr_op, wr_data) : direction;
  assign next_latch      = wr_latch      ? apply_op(latch, wr_op, wr_data) : latch;
  assign next_open_drain = wr_open_drain ? apply_op(open_drain, wr_op, wr_data) : open_drain;

  // direction and open-drain get defined reset values
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      direction  <= direction_reset;
      open_drain <= gpio_pkg::open_drain_reset;
    end else begin
      direction  <= next_direction;
      open_drain <= next_open_drain;
    end
  end

  // latch has no reset: contents undefined until first write
  always_ff @(posedge clock) begin
    latch <= next_latch;
  end

  // two-stage pin synchroniser, unimplemented pins forced to zero after it
  always_ff @(posedge clock) begin
    sync_stage <= pin_in;
    sync_out   <= sync_stage;
  end
  assign pin_sampled = sync_out & impl_mask;

  // output drive: open-drain drives only a low, oe_n low means driving
  assign pin_out  = latch & impl_mask;
  assign pin_oe_n = ~(~direction & impl_mask & ~(open_drain & latch));
endmodule : gpio_port_slice

// *** shared/gpio_pkg.sv ***
// gpio_pkg: register map, implemented-bit masks and reset values for ports a, b, c
// assumes a 32-bit apb slave with byte addresses matching the printed offsets
package gpio_pkg;
  localparam int unsigned  addr_width      = 16;
  localparam int unsigned  port_width      = 16;
  localparam int unsigned  num_ports       = 3;
  // register byte offsets
  localparam logic [15:0]  pin_direction_a      = 16'h6000;
  localparam logic [15:0]  pin_state_a          = 16'h6010;
  localparam logic [15:0]  output_latch_a       = 16'h6020;
  localparam logic [15:0]  open_drain_select_a  = 16'h6030;
  localparam logic [15:0]  pin_direction_b      = 16'h6040;
  localparam logic [15:0]  pin_state_b          = 16'h6050;
  localparam logic [15:0]  output_latch_b       = 16'h6060;
  localparam logic [15:0]  open_drain_select_b  = 16'h6070;
  localparam logic [15:0]  pin_direction_c      = 16'h6080;
  localparam logic [15:0]  pin_state_c          = 16'h6090;
  localparam logic [15:0]  output_latch_c       = 16'h60a0;
  localparam logic [15:0]  open_drain_select_c  = 16'h60b0;
  localparam logic [15:0]  map_base             = 16'h6000;
  localparam logic [15:0]  map_last             = 16'h60bf;
  // alias offsets within each 16-byte register slot
  localparam logic [1:0]   alias_base           = 2'h0;
  localparam logic [1:0]   bit_clear_alias      = 2'h1;
  localparam logic [1:0]   bit_set_alias        = 2'h2;
  localparam logic [1:0]   bit_invert_alias     = 2'h3;
  // register kind within a port (offset bits 5:4)
  localparam logic [1:0]   kind_direction       = 2'h0;
  localparam logic [1:0]   kind_state           = 2'h1;
  localparam logic [1:0]   kind_latch           = 2'h2;
  localparam logic [1:0]   kind_open_drain      = 2'h3;
  // implemented pin positions
  localparam logic [15:0]  mask_a               = 16'hc6ff;
  localparam logic [15:0]  mask_b               = 16'hffff;
  localparam logic [15:0]  mask_c               = 16'hf000;
  // reset values
  localparam logic [15:0]  direction_reset_a    = 16'hc6ff;
  localparam logic [15:0]  direction_reset_b    = 16'hffff;
  localparam logic [15:0]  direction_reset_c    = 16'hf000;
  localparam logic [15:0]  open_drain_reset     = 16'h0000;
  // value returned on alias reads; any value is allowed there
  localparam logic [31:0]  alias_read_value     = 32'h00000000;
endpackage : gpio_pkg

// *** verification/gpio_monitor.sv ***
// gpio_monitor: concurrent checks on the gpio block's pins and apb answers
// assumes it is bound to gpio_port_abc and sees only its ports
`timescale 1ns/10ps
module gpio_monitor (
  // clock, reset and apb
  input wire logic        clock, arst_n, psel, penable, pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  // pins
  input wire logic [15:0] pins_a_out, pins_a_oe_n, pins_b_out, pins_b_oe_n,
  input wire logic [15:0] pins_c_out, pins_c_oe_n
);
  // completed full-width writes and reads
  wire logic wr = psel && penable && pwrite && pstrb[1:0] == 2'h3;
  wire logic rd = psel && penable && !pwrite;
  wire logic [15:0] lb = gpio_pkg::output_latch_b;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_reset_inputs: assert property ($rose(arst_n) |-> &{pins_a_oe_n, pins_c_oe_n})
    else $error("pin driven right after reset");
  a_unimpl_pins: assert property (((pins_a_out | ~pins_a_oe_n) & ~gpio_pkg::mask_a) == 16'h0
    && ((pins_c_out | ~pins_c_oe_n) & ~gpio_pkg::mask_c) == 16'h0) else $error("absent pin active");
  a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0)
    else $error("upper halfword not zero");
  a_alias_read: assert property (rd && paddr[3:2] != 2'h0 |-> prdata == 32'h0)
    else $error("alias read value wrong");
  a_latch_write: assert property (wr && (paddr == lb || paddr == gpio_pkg::pin_state_b)
    |=> pins_b_out == $past(pwdata[15:0])) else $error("latch write lost");
  a_clear_alias: assert property (wr && paddr == lb + 16'h4
    |=> pins_b_out == ($past(pins_b_out) & ~$past(pwdata[15:0]))) else $error("clear wrong");
  a_set_alias: assert property (wr && paddr == lb + 16'h8
    |=> pins_b_out == ($past(pins_b_out) | $past(pwdata[15:0]))) else $error("set wrong");
  a_invert_alias: assert property (wr && paddr == lb + 16'hc
    |=> pins_b_out == ($past(pins_b_out) ^ $past(pwdata[15:0]))) else $error("invert wrong");
  a_input_released: assert property (wr && paddr == gpio_pkg::pin_direction_b
    |=> (pins_b_oe_n & $past(pwdata[15:0])) == $past(pwdata[15:0])) else $error("input driven");
endmodule : gpio_monitor

// *** verification/pin_board.sv ***
// pin_board: the board devices wired to one 16-pin port
// assumes the bench sets the level that the board puts on released pins
`timescale 1ns/10ps
module pin_board (
  // device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  // board side
  input  wire logic [15:0] ext_level,
  output logic      [15:0] pin_level
);
  // a driven bit wins; a released bit follows the board
  assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pin_board

// *** verification/tb.sv ***
// tb: register, alias and pin tests for the gpio port block
// assumes a pin_board model on each port and an apb master in this module
`timescale 1ns/10ps
module tb;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr, ext_a, ext_b, ext_c, pins_a_in, pins_a_out, pins_a_oe_n;
  logic [15:0] pins_b_in, pins_b_out, pins_b_oe_n, pins_c_in, pins_c_out, pins_c_oe_n;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          num_errors, n_compared;
  localparam logic [15:0] dir_rst [3] = '{16'hc6ff, 16'hffff, 16'hf000};
  localparam logic [15:0] pat [4] = '{16'h0, 16'hf0f0, 16'h1003, 16'h8181};
  gpio_port_abc gpio_port_abc_i (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pins_a_in, .pins_a_out, .pins_a_oe_n, .pins_b_in,
    .pins_b_out, .pins_b_oe_n, .pins_c_in, .pins_c_out, .pins_c_oe_n);
  pin_board pin_board_a (.pin_out(pins_a_out), .pin_oe_n(pins_a_oe_n), .ext_level(ext_a),
    .pin_level(pins_a_in));
  pin_board pin_board_b (.pin_out(pins_b_out), .pin_oe_n(pins_b_oe_n), .ext_level(ext_b),
    .pin_level(pins_b_in));
  pin_board pin_board_c (.pin_out(pins_c_out), .pin_oe_n(pins_c_oe_n), .ext_level(ext_c),
    .pin_level(pins_c_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] adr(input int p, input int k);
    return gpio_pkg::map_base + 16'(p * 64 + k * 16);
  endfunction : adr
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic t_reset;
    for (int p = 0; p < 3; p++) begin
      apb(1'b0, adr(p, 0), 32'h0, rd, err);
      check(rd, {16'h0, dir_rst[p]});
      apb(1'b0, adr(p, 3), 32'h0, rd, err);
      check(rd, 32'h0);
    end
  endtask : t_reset
  // latch written through pin-state, then each alias on top
  task automatic t_alias;
    logic [15:0] exp;
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, adr(p, 1), 32'hffffffff, rd, err);
      exp = dir_rst[p];
      for (int op = 1; op < 4; op++) begin
        apb(1'b1, adr(p, 2) + 16'(op * 4), {16'hffff, pat[op]}, rd, err);
        exp = op == 1 ? exp & ~pat[op] : op == 2 ? exp | pat[op] : exp ^ pat[op];
        exp &= dir_rst[p];
        apb(1'b0, adr(p, 2), 32'h0, rd, err);
        check(rd, {16'h0, exp});
        apb(1'b0, adr(p, 2) + 16'(op * 4), 32'h0, rd, err);
      end
    end
  endtask : t_alias
  // low byte of b driven, bit 0 open-drain released; a read as inputs
  task automatic t_pins;
    apb(1'b1, gpio_pkg::output_latch_b, 32'h00a5, rd, err);
    apb(1'b1, gpio_pkg::pin_direction_b, 32'hff00, rd, err);
    apb(1'b1, gpio_pkg::open_drain_select_b, 32'h0001, rd, err);
    repeat (4) @(posedge clock);
    @(negedge clock);
    check({pins_b_oe_n, pins_b_out}, 32'hff0100a5);
    apb(1'b0, gpio_pkg::pin_state_b, 32'h0, rd, err);
    check(rd, 32'h00a4);
    apb(1'b0, gpio_pkg::pin_state_a, 32'h0, rd, err);
    check(rd, 32'h423c);
    apb(1'b0, 16'h60c0, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1);
  endtask : t_pins
  task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // main sequence
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h0, 16'h0, 32'h0, 4'hf};
    {ext_a, ext_b, ext_c} = {16'h5a3c, 16'h0, 16'h0};
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_reset;
    t_alias;
    t_pins;
    report_and_stop;
  end
  // watchdog, far beyond the roughly 140 cycles the tests take
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
endmodule : tb
bind gpio_port_abc gpio_monitor gpio_monitor_i (.clock, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pstrb, .pins_a_out, .pins_a_oe_n, .pins_b_out, .pins_b_oe_n,
  .pins_c_out, .pins_c_oe_n);
